// [rtl/memsel_cfg.svh]
// constants for the memory select decoder and its bus partner
// assumes a 50 MHz reference clock and 8-bit registers
`ifndef MEMSEL_CFG_SVH
`define MEMSEL_CFG_SVH

// ----------------------------------------------------------------
// register space
// ----------------------------------------------------------------
`define REG_BASE_HI      8'hF0
`define OFS_PAGE         8'hE0
`define OFS_SPACE_MAP    8'hE2
`define OFS_POWER0       8'hB0
`define OFS_POWER2       8'hB4
`define PAGE_RST         8'h00
`define SPACE_MAP_INIT   8'h0C
`define POWER0_RST       8'h00
`define POWER2_RST       8'h00
`define PIO_HI0          8'hF1
`define PIO_HI1          8'hF2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MAP_PERIPHERAL_IO_ENABLE       7
`define MAP_PRI_DATA     4
`define MAP_SEC_DATA     3
`define MAP_PRI_CODE     2
`define MAP_SEC_CODE     1
`define MAP_SRAM_CODE    0
`define PWR0_FAST        3
`define PWR2_BLK_FETCH   0
`define PWR2_BLK_RD      1
`define PWR2_BLK_WR      2
`define PWR2_BLK_ALE     3
`define PWR2_BLK_PDN     4

// ----------------------------------------------------------------
// flash instruction and timing
// ----------------------------------------------------------------
`define FLASH_RESET_CODE 8'hF0
`define FLASH_RESET_ADDR 16'h9000
`define CLK_PERIOD_NS    20
`define RECOVER_NS       25000
`define RECOVER_CYC      (`RECOVER_NS / `CLK_PERIOD_NS)
`define STANDBY_NS       70
`define STANDBY_CYC      ((`STANDBY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_PROGRAM       2'h1
`define OP_BULK          2'h2
`define OP_SECTOR        2'h3

`endif

// [rtl/memsel_pkg.sv]
// types shared by both ends of the memory select link
// assumes memsel_cfg.svh holds the numbers
`default_nettype none
package memsel_pkg;
  typedef enum logic [5:0] {
    FL_READ    = 6'h01,
    FL_PROGRAM = 6'h02,
    FL_BULK    = 6'h04,
    FL_SECTOR  = 6'h08,
    FL_ERROR   = 6'h10,
    FL_RECOVER = 6'h20
  } flash_state_e;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'h1,
    HS_RESET = 3'h2,
    HS_READ  = 3'h4
  } host_state_e;
endpackage
`default_nettype wire

// [rtl/memsel_if.sv]
// bus between the mcu side and the memory select decoder
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface memsel_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rd;
  logic        wr;
  logic        program_fetch_strobe;
  logic        ale;
  logic        rst_pulse;
  logic        power_down_input;
  logic [7:0]  primary_sector_selects;
  logic [3:0]  secondary_sector_selects;
  logic        sram_select;
  logic        io_select;
  logic [1:0]  pio_select;
  logic        ready_busy;
  logic        error_flag_bit;

  modport dev (
    input  addr, wdata, rd, wr, program_fetch_strobe, ale, rst_pulse,
    input  power_down_input,
    output rdata, primary_sector_selects, secondary_sector_selects,
    output sram_select, io_select, pio_select, ready_busy, error_flag_bit
  );
  modport host (
    output addr, wdata, rd, wr, program_fetch_strobe, ale, rst_pulse,
    output power_down_input,
    input  rdata, primary_sector_selects, secondary_sector_selects,
    input  sram_select, io_select, pio_select, ready_busy, error_flag_bit
  );
endinterface
`default_nettype wire

// [rtl/memory_select_decode.sv]
// device end: decoder, page and mapping registers, flash mode control
// assumes the partner drives the bus on i_ref_clk, one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
`include "memsel_cfg.svh"
module memory_select_decode (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  memsel_if.dev                       bus,
  input  wire logic [1:0]             i_array_op,
  input  wire logic                   i_array_done,
  input  wire logic                   i_array_error,
  output logic [7:0]                  o_page_outputs,
  output logic                        o_standby,
  output memsel_pkg::flash_state_e    o_flash_state
);
  import memsel_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]   page_q, page_d;
  logic [7:0]   map_q, map_d;
  logic [7:0]   pwr0_q, pwr0_d;
  logic [7:0]   pwr2_q, pwr2_d;
  logic [7:0]   rdata_q, rdata_d;
  flash_state_e fl_q, fl_d;
  logic [10:0]  rcv_q, rcv_d;
  logic [2:0]   idle_q, idle_d;
  logic [30:0]  prev_q;
  logic         stby_q;

  // ----------------------------------------------------------------
  // strobe gating and activity
  // ----------------------------------------------------------------
  wire fetch_en = bus.program_fetch_strobe
                  & ~pwr2_q[`PWR2_BLK_FETCH];
  wire rd_en    = bus.rd & ~pwr2_q[`PWR2_BLK_RD];
  wire wr_en    = bus.wr & ~pwr2_q[`PWR2_BLK_WR];
  wire ale_en   = bus.ale & ~pwr2_q[`PWR2_BLK_ALE];
  wire pdn_en   = bus.power_down_input & ~pwr2_q[`PWR2_BLK_PDN];
  wire busy     = (fl_q != FL_READ) && (fl_q != FL_ERROR);

  // every decoder input but map_q, watched for the standby timer
  wire [30:0] dec_in = {bus.addr, fetch_en, rd_en, wr_en, ale_en,
                        bus.rst_pulse, pdn_en, page_q, busy};

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire io_hit   = bus.addr[15:8] == `REG_BASE_HI;
  wire [1:0] pio_hit;
  assign pio_hit[0] = map_q[`MAP_PERIPHERAL_IO_ENABLE]
                      & (bus.addr[15:8] == `PIO_HI0);
  assign pio_hit[1] = map_q[`MAP_PERIPHERAL_IO_ENABLE]
                      & (bus.addr[15:8] == `PIO_HI1);
  // two product terms; the paged one reaches sram at 8000h-87FFh
  wire sram_hit = (bus.addr[15:13] == 3'h3)
                | ((bus.addr[15:11] == 5'h10) & page_q[7]);
  wire level1   = sram_hit | io_hit | (|pio_hit);

  // strobes that may reach each memory
  wire pri_ok  = (rd_en & map_q[`MAP_PRI_DATA])
               | (fetch_en & map_q[`MAP_PRI_CODE]) | wr_en;
  wire sec_ok  = (rd_en & map_q[`MAP_SEC_DATA])
               | (fetch_en & map_q[`MAP_SEC_CODE]) | wr_en;
  wire sram_ok = rd_en | wr_en | (fetch_en & map_q[`MAP_SRAM_CODE]);
  wire data_ok = rd_en | wr_en;

  wire [3:0] sec_hit;
  wire [7:0] pri_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pri
      // page picks one 32k primary sector in the upper half
      assign pri_hit[gi] = bus.addr[15] & (page_q[2:0] == 3'(gi));
      if (gi < 4) begin : g_sec
        assign sec_hit[gi] = (bus.addr[15:13] == {1'b0, 2'(gi)});
      end
    end
  endgenerate
  wire any_sec = |sec_hit;

  // level 1 beats level 2 beats level 3
  assign bus.sram_select = sram_hit & sram_ok;
  assign bus.io_select   = io_hit & data_ok & ~sram_hit;
  assign bus.pio_select  = pio_hit & {2{data_ok}};
  assign bus.secondary_sector_selects =
           sec_hit & {4{sec_ok & ~level1}};
  assign bus.primary_sector_selects =
           pri_hit & {8{pri_ok & ~level1 & ~any_sec}};
  assign bus.rdata          = rdata_q;
  assign bus.ready_busy     = ~busy;
  assign bus.error_flag_bit = (fl_q == FL_ERROR);

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  wire reg_wr  = bus.wr & io_hit;
  wire reg_rd  = bus.rd & io_hit;
  wire wr_page = reg_wr & (bus.addr[7:0] == `OFS_PAGE);
  wire wr_map  = reg_wr & (bus.addr[7:0] == `OFS_SPACE_MAP);
  wire wr_pw0  = reg_wr & (bus.addr[7:0] == `OFS_POWER0);
  wire wr_pw2  = reg_wr & (bus.addr[7:0] == `OFS_POWER2);

  assign page_d = wr_page ? bus.wdata : page_q;
  assign map_d  = wr_map ? {bus.wdata[7], 2'b00, bus.wdata[4:0]}
                         : map_q;
  assign pwr0_d = wr_pw0 ? {4'h0, bus.wdata[3], 3'h0} : pwr0_q;
  assign pwr2_d = wr_pw2 ? {3'h0, bus.wdata[4:0]} : pwr2_q;

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (bus.addr[7:0])
        `OFS_PAGE:      rdata_d = page_q;
        `OFS_SPACE_MAP: rdata_d = map_q;
        `OFS_POWER0:    rdata_d = pwr0_q;
        `OFS_POWER2:    rdata_d = pwr2_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flash mode control
  // ----------------------------------------------------------------
  // the unlock pair is harmless either way, so a lone write counts
  wire flash_wr = wr_en & ~level1 & (bus.addr[15] | any_sec);
  wire rst_cmd  = flash_wr & (bus.wdata == `FLASH_RESET_CODE);
  wire rcv_done = rcv_q == 11'(`RECOVER_CYC - 1);

  always_comb begin
    fl_d  = fl_q;
    rcv_d = 11'h000;
    case (fl_q)
      FL_READ: begin
        if (i_array_op == `OP_PROGRAM) fl_d = FL_PROGRAM;
        else if (i_array_op == `OP_BULK) fl_d = FL_BULK;
        else if (i_array_op == `OP_SECTOR) fl_d = FL_SECTOR;
      end
      FL_PROGRAM, FL_BULK: begin
        // a reset instruction here is dropped on purpose
        if (bus.rst_pulse) fl_d = FL_RECOVER;
        else if (i_array_done) fl_d = i_array_error ? FL_ERROR : FL_READ;
      end
      FL_SECTOR: begin
        if (bus.rst_pulse | rst_cmd) fl_d = FL_RECOVER;
        else if (i_array_done) fl_d = i_array_error ? FL_ERROR : FL_READ;
      end
      FL_ERROR: begin
        if (bus.rst_pulse) fl_d = FL_READ;
        else if (rst_cmd) fl_d = FL_RECOVER;
      end
      FL_RECOVER: begin
        rcv_d = rcv_q + 11'h001;
        if (rcv_done) fl_d = FL_READ;
      end
      default: fl_d = FL_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // standby timer
  // ----------------------------------------------------------------
  wire idle_now = (dec_in == prev_q);
  assign idle_d = !idle_now ? 3'h0
                : (idle_q == 3'(`STANDBY_CYC)) ? idle_q : idle_q + 3'h1;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      page_q  <= `PAGE_RST;
      map_q   <= `SPACE_MAP_INIT;
      pwr0_q  <= `POWER0_RST;
      pwr2_q  <= `POWER2_RST;
      rdata_q <= 8'h00;
      fl_q    <= FL_READ;
      rcv_q   <= 11'h000;
      idle_q  <= 3'h0;
      prev_q  <= 31'h00000000;
      stby_q  <= 1'b0;
    end else begin
      page_q  <= page_d;
      map_q   <= map_d;
      pwr0_q  <= pwr0_d;
      pwr2_q  <= pwr2_d;
      rdata_q <= rdata_d;
      fl_q    <= fl_d;
      rcv_q   <= rcv_d;
      idle_q  <= idle_d;
      prev_q  <= dec_in;
      stby_q  <= ~pwr0_q[`PWR0_FAST] & idle_now
                 & (idle_q == 3'(`STANDBY_CYC));
    end
  end

  // outputs taken from flops only
  logic [7:0]   page_out_q;
  flash_state_e fl_out_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      page_out_q <= `PAGE_RST;
      fl_out_q   <= FL_READ;
    end else begin
      page_out_q <= page_q;
      fl_out_q   <= fl_q;
    end
  end
  assign o_page_outputs = page_out_q;
  assign o_standby      = stby_q;
  assign o_flash_state  = fl_out_q;
endmodule
`default_nettype wire

// [rtl/memsel_host.sv]
// partner end: copies user requests to bus strobes a cycle later; a reset request holds rst_pulse for RECOVER_CYC cycles
// assumes the decoder shares i_ref_clk and answers reads next cycle
`timescale 1ns/100ps
`default_nettype none
`include "memsel_cfg.svh"
module memsel_host (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  memsel_if.host           bus,
  input  wire logic        i_req_wr,
  input  wire logic        i_req_rd,
  input  wire logic        i_req_fetch,
  input  wire logic [15:0] i_req_addr,
  input  wire logic [7:0]  i_req_wdata,
  input  wire logic        i_req_reset,
  input  wire logic        i_power_down,
  output logic [7:0]       o_rdata,
  output logic             o_rdata_valid,
  output logic             o_busy
);
  import memsel_pkg::*;

  host_state_e st_q, st_d;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q, rdata_q;
  logic        rd_q, wr_q, fetch_q, pdn_q, valid_q, pend_q, err_q;
  logic        rd_dly_q;
  logic [10:0] hold_q;

  // ----------------------------------------------------------------
  // request selection
  // ----------------------------------------------------------------
  wire err_rise = bus.error_flag_bit & ~err_q;
  wire free     = (st_q != HS_RESET);
  wire user_req = free & (i_req_wr | i_req_rd | i_req_fetch);
  wire auto_wr  = free & ~i_req_reset & ~user_req & pend_q;
  wire hold_end = hold_q == 11'(`RECOVER_CYC - 1);

  always_comb begin
    st_d = st_q;
    case (st_q)
      HS_IDLE:  if (i_req_reset) st_d = HS_RESET;
                else if (i_req_rd | i_req_fetch) st_d = HS_READ;
      HS_READ:  if (i_req_reset) st_d = HS_RESET;
                else if (!(i_req_rd | i_req_fetch)) st_d = HS_IDLE;
      HS_RESET: if (hold_end) st_d = HS_IDLE;
      default:  st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q    <= HS_IDLE;
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      fetch_q <= 1'b0;
      pdn_q   <= 1'b0;
      rdata_q <= 8'h00;
      valid_q <= 1'b0;
      rd_dly_q <= 1'b0;
      pend_q  <= 1'b0;
      err_q   <= 1'b0;
      hold_q  <= 11'h000;
    end else begin
      st_q    <= st_d;
      pdn_q   <= i_power_down;
      err_q   <= bus.error_flag_bit;
      // a new error wins over the clear of the one just issued
      pend_q  <= err_rise | (pend_q & ~auto_wr);
      rd_q    <= user_req & ~i_req_reset & i_req_rd;
      fetch_q <= user_req & ~i_req_reset & ~i_req_rd & i_req_fetch;
      wr_q    <= (user_req & ~i_req_reset & ~i_req_rd & ~i_req_fetch)
                 | auto_wr;
      if (auto_wr) begin
        addr_q  <= `FLASH_RESET_ADDR;
        wdata_q <= `FLASH_RESET_CODE;
      end else if (user_req) begin
        addr_q  <= i_req_addr;
        wdata_q <= i_req_wdata;
      end
      hold_q  <= (st_q == HS_RESET) ? hold_q + 11'h001 : 11'h000;
      // read data stand only in the cycle after the strobe: take them then
      rd_dly_q <= rd_q | fetch_q;
      valid_q <= rd_dly_q;
      if (rd_dly_q) rdata_q <= bus.rdata;
    end
  end

  assign bus.addr                 = addr_q;
  assign bus.wdata                = wdata_q;
  assign bus.rd                   = rd_q;
  assign bus.wr                   = wr_q;
  assign bus.program_fetch_strobe = fetch_q;
  assign bus.ale                  = rd_q | wr_q | fetch_q;
  assign bus.rst_pulse            = (st_q == HS_RESET);
  assign bus.power_down_input     = pdn_q;
  assign o_rdata       = rdata_q;
  assign o_rdata_valid = valid_q;
  assign o_busy        = (st_q == HS_RESET);
endmodule
`default_nettype wire

// [verification/memsel_properties.sv]
// checker for the bus between the host end and the select decoder
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "memsel_cfg.svh"
module memsel_properties (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic        program_fetch_strobe,
  input wire logic        rst_pulse,
  input wire logic [7:0]  primary_sector_selects,
  input wire logic [3:0]  secondary_sector_selects,
  input wire logic        sram_select,
  input wire logic        io_select,
  input wire logic [1:0]  pio_select,
  input wire logic        ready_busy,
  input wire logic        error_flag_bit
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ------------------------------------------------------------
  // decode priority and windows
  // ------------------------------------------------------------
  a_sram_beats_flash:
    assert property (sram_select |-> primary_sector_selects == 8'h00
                     && secondary_sector_selects == 4'h0)
      else $error("sram select overlaps a flash select");
  a_io_beats_flash:
    assert property ((io_select || pio_select != 2'h0)
                     |-> primary_sector_selects == 8'h00)
      else $error("io select overlaps a primary select");
  a_sec_beats_pri:
    assert property (secondary_sector_selects != 4'h0
                     |-> primary_sector_selects == 8'h00)
      else $error("secondary and primary selected together");
  a_sec_window:
    assert property (secondary_sector_selects != 4'h0 |-> !addr[15]
                     && secondary_sector_selects == (4'h1 << addr[14:13]))
      else $error("secondary select outside its window");
  a_io_window:
    assert property (io_select |-> addr[15:8] == `REG_BASE_HI)
      else $error("io select outside register space");
  a_sram_enable:
    assert property (sram_select |-> rd || wr || program_fetch_strobe)
      else $error("sram selected with no strobe");
  a_pri_onehot:
    assert property ($onehot0(primary_sector_selects))
      else $error("more than one primary select");
  a_level_apart:
    assert property ($onehot0({sram_select, io_select, pio_select})
                     && $onehot0(secondary_sector_selects))
      else $error("same-level selects overlap");

  // ------------------------------------------------------------
  // register read data and flash mode
  // ------------------------------------------------------------
  a_rdata_idle:
    assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data present without a read");
  a_reset_instr:
    assert property (error_flag_bit && wr && wdata == `FLASH_RESET_CODE
                     && addr == `FLASH_RESET_ADDR
                     |=> !ready_busy && !error_flag_bit)
      else $error("reset instruction did not leave error state");
  a_pulse_clears:
    assert property (rst_pulse && error_flag_bit |=> !error_flag_bit)
      else $error("reset pulse did not clear error state");
  a_pulse_held:
    assert property ($rose(rst_pulse) |-> rst_pulse [*8])
      else $error("reset pulse too short");

  c_sram: cover property (sram_select);
  c_secondary: cover property (secondary_sector_selects != 4'h0);
  c_busy: cover property ($fell(ready_busy));
  c_error_cleared: cover property (error_flag_bit ##1 !error_flag_bit);
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench: host end and decoder joined by the interface
// assumes 50 MHz clock, sync active-low reset held four cycles
`timescale 1ns/100ps
`default_nettype none
`include "memsel_cfg.svh"
module testbench;
  import memsel_pkg::*;
  logic         i_ref_clk, i_rst_n, req_wr, req_rd, req_fetch, req_reset;
  logic         power_down, array_done, array_error, rdata_valid, busy;
  logic         standby;
  logic [1:0]   array_op;
  logic [15:0]  req_addr;
  logic [7:0]   req_wdata, rdata, page_out;
  flash_state_e flash_state;
  int           n_fail, compares, cycles;

  memsel_if bus_if ();
  memory_select_decode i_memory_select_decode (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .bus(bus_if), .i_array_op(array_op),
    .i_array_done(array_done), .i_array_error(array_error),
    .o_page_outputs(page_out), .o_standby(standby),
    .o_flash_state(flash_state));
  memsel_host i_memsel_host (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .bus(bus_if), .i_req_wr(req_wr), .i_req_rd(req_rd),
    .i_req_fetch(req_fetch), .i_req_addr(req_addr),
    .i_req_wdata(req_wdata), .i_req_reset(req_reset),
    .i_power_down(power_down), .o_rdata(rdata),
    .o_rdata_valid(rdata_valid), .o_busy(busy));
  memsel_properties i_memsel_properties (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .rd(bus_if.rd), .wr(bus_if.wr),
    .program_fetch_strobe(bus_if.program_fetch_strobe),
    .rst_pulse(bus_if.rst_pulse),
    .primary_sector_selects(bus_if.primary_sector_selects),
    .secondary_sector_selects(bus_if.secondary_sector_selects),
    .sram_select(bus_if.sram_select), .io_select(bus_if.io_select),
    .pio_select(bus_if.pio_select), .ready_busy(bus_if.ready_busy),
    .error_flag_bit(bus_if.error_flag_bit));

  // ------------------------------------------------------------
  // clock, closing report, shared tasks
  // ------------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // three recoveries of 1250 cycles plus traffic fit well inside this
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // kind 0 read, 1 fetch, 2 write; selects sampled in the strobe cycle
  task automatic access(input int kind, input logic [15:0] a,
                        input logic [7:0] d, output logic [15:0] sel,
                        output logic [7:0] rv);
    @(posedge i_ref_clk);
    req_rd    <= (kind == 0);
    req_fetch <= (kind == 1);
    req_wr    <= (kind == 2);
    req_addr  <= a;
    req_wdata <= d;
    @(posedge i_ref_clk);
    req_rd    <= 1'b0;
    req_fetch <= 1'b0;
    req_wr    <= 1'b0;
    #1;
    sel = {bus_if.sram_select, bus_if.io_select, bus_if.pio_select,
           bus_if.secondary_sector_selects, bus_if.primary_sector_selects};
    @(posedge i_ref_clk);
    #1;
    rv = bus_if.rdata;
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [15:0] sel;
    logic [7:0]  rv;
    access(2, {`REG_BASE_HI, ofs}, d, sel, rv);
  endtask

  task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [15:0] sel;
    logic [7:0]  rv;
    access(0, {`REG_BASE_HI, ofs}, 8'h00, sel, rv);
    check({8'h00, rv}, {8'h00, exp});
    check({7'h00, rdata_valid, rdata}, {8'h01, exp});
  endtask

  task automatic decode(input int kind, input logic [15:0] a,
                        input logic [15:0] exp);
    logic [15:0] sel;
    logic [7:0]  rv;
    access(kind, a, 8'h00, sel, rv);
    check(sel, exp);
  endtask

  task automatic pulse_op(input logic [1:0] op);
    @(posedge i_ref_clk);
    array_op <= op;
    @(posedge i_ref_clk);
    array_op <= 2'h0;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic finish_op(input logic err);
    @(posedge i_ref_clk);
    array_done  <= 1'b1;
    array_error <= err;
    @(posedge i_ref_clk);
    array_done  <= 1'b0;
    array_error <= 1'b0;
  endtask

  task automatic wait_read(output int n);
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (!(bus_if.ready_busy === 1'b1 && flash_state === FL_READ)
               && n < 3000);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_registers();
    reg_rd(`OFS_PAGE, `PAGE_RST);
    reg_rd(`OFS_SPACE_MAP, `SPACE_MAP_INIT);
    reg_rd(`OFS_POWER0, `POWER0_RST);
    reg_rd(`OFS_POWER2, `POWER2_RST);
    reg_rd(8'hE4, 8'h00);
    reg_wr(`OFS_PAGE, 8'hA5);
    reg_rd(`OFS_PAGE, 8'hA5);
    check({8'h00, page_out}, 16'h00A5);
    reg_wr(`OFS_SPACE_MAP, 8'hFF);
    reg_rd(`OFS_SPACE_MAP, 8'h9F);
  endtask

  task automatic t_spaces();
    reg_wr(`OFS_PAGE, 8'h00);
    reg_wr(`OFS_SPACE_MAP, 8'h0C);
    decode(1, 16'h9000, 16'h0001);
    decode(0, 16'h9000, 16'h0000);
    decode(0, 16'h0000, 16'h0100);
    decode(1, 16'h0000, 16'h0000);
    decode(0, 16'h6000, 16'h8000);
    decode(1, 16'h6000, 16'h0000);
    decode(0, 16'hF000, 16'h4000);
    reg_wr(`OFS_SPACE_MAP, 8'h14);
    decode(0, 16'h9000, 16'h0001);
    decode(1, 16'h9000, 16'h0001);
    reg_wr(`OFS_SPACE_MAP, 8'h9C);
    reg_wr(`OFS_PAGE, 8'h83);
    decode(0, 16'h8000, 16'h8000);
    decode(0, 16'h8800, 16'h0008);
    decode(0, 16'hF100, 16'h1000);
    decode(0, 16'hF200, 16'h2000);
    reg_wr(`OFS_SPACE_MAP, 8'h0C);
    reg_wr(`OFS_PAGE, 8'h00);
  endtask

  task automatic t_power();
    @(posedge i_ref_clk);
    power_down <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    power_down <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    #1;
    check({15'h0, standby}, 16'h0001);
    reg_wr(`OFS_POWER0, 8'h08);
    repeat (10) @(posedge i_ref_clk);
    #1;
    check({15'h0, standby}, 16'h0000);
    reg_wr(`OFS_POWER0, 8'h00);
    reg_wr(`OFS_POWER2, 8'h01);
    decode(1, 16'h9000, 16'h0000);
    reg_wr(`OFS_POWER2, 8'h02);
    decode(0, 16'h0000, 16'h0000);
    reg_rd(`OFS_POWER2, 8'h02);
    reg_wr(`OFS_POWER2, 8'h00);
  endtask

  task automatic t_flash();
    logic [15:0] sel;
    logic [7:0]  rv;
    int          n;
    pulse_op(2'h3);
    check({10'h0, flash_state}, {10'h0, FL_SECTOR});
    access(2, 16'h0555, 8'hAA, sel, rv);
    access(2, 16'h0AAA, 8'h55, sel, rv);
    access(2, `FLASH_RESET_ADDR, `FLASH_RESET_CODE, sel, rv);
    wait_read(n);
    check(16'(n >= `RECOVER_CYC - 8 && n <= `RECOVER_CYC + 8), 16'h1);
    for (int op = 1; op <= 2; op++) begin
      pulse_op(op[1:0]);
      access(2, `FLASH_RESET_ADDR, `FLASH_RESET_CODE, sel, rv);
      check({10'h0, flash_state},
            {10'h0, (op == 1) ? FL_PROGRAM : FL_BULK});
      finish_op(1'b0);
      wait_read(n);
      check(16'(n <= 8), 16'h1);
    end
    pulse_op(2'h1);
    finish_op(1'b1);
    wait_read(n);
    check(16'(n >= `RECOVER_CYC - 8 && n <= `RECOVER_CYC + 20), 16'h1);
    check({15'h0, bus_if.error_flag_bit}, 16'h0);
  endtask

  task automatic t_pulse();
    int n;
    pulse_op(2'h3);
    @(posedge i_ref_clk);
    req_reset <= 1'b1;
    @(posedge i_ref_clk);
    req_reset <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    check({15'h0, busy}, 16'h0001);
    check({10'h0, flash_state}, {10'h0, FL_RECOVER});
    wait_read(n);
    check(16'(n <= `RECOVER_CYC + 8), 16'h1);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check({15'h0, busy}, 16'h0000);
    // pulse while the error state stands: straight back to read
    pulse_op(2'h1);
    @(posedge i_ref_clk);
    array_done  <= 1'b1;
    array_error <= 1'b1;
    req_reset   <= 1'b1;
    @(posedge i_ref_clk);
    array_done  <= 1'b0;
    array_error <= 1'b0;
    req_reset   <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    check({10'h0, flash_state}, {10'h0, FL_READ});
    check({15'h0, bus_if.error_flag_bit}, 16'h0);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check({15'h0, busy}, 16'h0000);
  endtask

  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    i_rst_n = 1'b0;
    {req_wr, req_rd, req_fetch, req_reset, power_down} = 5'h00;
    {array_done, array_error} = 2'h0;
    array_op = 2'h0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_registers();
    t_spaces();
    t_power();
    t_flash();
    t_pulse();
    conclude();
  end
endmodule
`default_nettype wire
